// ### shared/power_clock_pkg.sv
package power_clock_pkg;

   // Register byte offsets
   localparam logic [7:0] reset_control_off     = 8'h00;
   localparam logic [7:0] clock_divisor_off     = 8'h04;
   localparam logic [7:0] oscillator_control_off = 8'h08;
   localparam logic [7:0] module_disable_off    = 8'h0c;
   localparam logic [7:0] stop_in_idle_off      = 8'h10;
   localparam logic [7:0] power_status_off      = 8'h14;

   // Reset control fields
   localparam int main_reg_stby_pos  = 8;
   localparam int flash_reg_stby_pos = 11;

   // Clock divisor fields
   localparam int recover_on_int_pos = 15;
   localparam int doze_ratio_hi      = 14;
   localparam int doze_ratio_lo      = 12;
   localparam int doze_enable_pos    = 11;

   // Oscillator control fields
   localparam int new_osc_hi = 10;
   localparam int new_osc_lo = 8;
   localparam int cur_osc_hi = 2;
   localparam int cur_osc_lo = 0;

   // Stop-in-idle bit of timer one, as kept in its control register
   localparam int timer_stop_in_idle_pos = 13;

   // Status fields
   localparam int stat_state_lo = 0;
   localparam int stat_sleep_pos = 2;
   localparam int stat_doze_pos  = 3;
   localparam int stat_cur_osc_lo = 4;

   // Reset values
   localparam logic [2:0] doze_ratio_rst = 3'h0;
   localparam logic [2:0] osc_sel_rst    = 3'h0;

   // Wake-up delay from Sleep or Idle, in clock cycles (2 to 4 allowed)
   localparam int wake_delay_cycles = 2;
   localparam int wake_delay_min    = 2;
   localparam int wake_delay_max    = 4;
   localparam int doze_count_w      = 7;

   typedef enum logic [1:0] {
      ps_run   = 2'b00,
      ps_enter = 2'b01,
      ps_low   = 2'b11,
      ps_wake  = 2'b10
   } power_state_t;

   typedef struct packed {
      logic       main_reg_active;
      logic       flash_reg_active;
      logic       recover_on_int;
      logic [2:0] doze_ratio;
      logic       doze_enable;
      logic [2:0] new_osc_sel;
   } ctrl_regs_t;

   typedef struct packed {
      logic cpu_clk_en;
      logic sys_clk_run;
      logic onchip_osc_on;
      logic low_power_rc_run;
      logic fail_safe_active;
      logic main_reg_standby;
      logic flash_reg_standby;
   } clock_out_t;

endpackage : power_clock_pkg

// ### rtl/power_saving_clock_control.sv
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module power_saving_clock_control #(
   parameter int          num_periph   = 8,
   parameter logic [31:0] present_mask = 32'h0000_00ff,
   parameter logic [31:0] ext_clk_mask = 32'h0000_0000,
   parameter int          wake_cycles  = power_clock_pkg::wake_delay_cycles
) (
   // Clock, reset, enable
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  clk_en,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic                       pready,
   output logic [31:0]                prdata,
   output logic                       pslverr,
   // CPU core side
   input  wire logic                  power_save_instruction,
   input  wire logic                  power_save_sleep,
   input  wire logic                  irq_pending,
   input  wire logic                  watchdog_timer_en,
   input  wire logic                  watchdog_timer_timeout,
   input  wire logic                  fail_safe_clock_monitor_en,
   input  wire logic                  clock_config_locked,
   input  wire logic                  osc_switch_done,
   output logic                       irq_hold,
   output logic                       cpu_resume,
   output logic                       watchdog_timer_clear,
   output logic                       osc_switch_start,
   output logic [2:0]                 osc_switch_sel,
   // Clock and power outputs
   output power_clock_pkg::clock_out_t clk_out,
   // Peripheral side
   output logic [num_periph-1:0]      periph_clk_en,
   output logic [num_periph-1:0]      periph_regs_en
);
   import power_clock_pkg::*;

   typedef struct packed {
      power_state_t              state;
      logic                      in_sleep;
      ctrl_regs_t                ctrl;
      logic [num_periph-1:0]     module_disable;
      logic [num_periph-1:0]     md_effective;
      logic [num_periph-1:0]     stop_in_idle;
      logic [2:0]                cur_osc;
      logic [2:0]                saved_osc;
      logic [2:0]                wake_cnt;
      logic [doze_count_w-1:0]   doze_cnt;
      logic                      resume;
      logic                      wdt_clear;
      logic                      sw_start;
      logic [31:0]               rdata;
      logic                      rerr;
   } state_t;

   state_t r_reg;
   state_t r_next;

   // Elaboration checks
   if (num_periph < 1 || num_periph > 32) begin : g_bad_num
      $error("num_periph must be 1 to 32");
   end
   if (wake_cycles < wake_delay_min || wake_cycles > wake_delay_max) begin : g_bad_wake
      $error("wake_cycles must be 2 to 4");
   end

   // Unmapped offsets answer with an error, not silence
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == reset_control_off) || (a == clock_divisor_off) ||
               (a == oscillator_control_off) || (a == module_disable_off) ||
               (a == stop_in_idle_off) || (a == power_status_off);
   endfunction : mapped

   function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         reset_control_off: begin
            w[main_reg_stby_pos]  = s.ctrl.main_reg_active;
            w[flash_reg_stby_pos] = s.ctrl.flash_reg_active;
         end
         clock_divisor_off: begin
            w[recover_on_int_pos]           = s.ctrl.recover_on_int;
            w[doze_ratio_hi:doze_ratio_lo]  = s.ctrl.doze_ratio;
            w[doze_enable_pos]              = s.ctrl.doze_enable;
         end
         oscillator_control_off: begin
            w[new_osc_hi:new_osc_lo] = s.ctrl.new_osc_sel;
            w[cur_osc_hi:cur_osc_lo] = s.cur_osc;
         end
         module_disable_off: begin
            w[num_periph-1:0] = s.module_disable;
         end
         stop_in_idle_off: begin
            w[num_periph-1:0] = s.stop_in_idle;
         end
         power_status_off: begin
            w[stat_state_lo +: 2]          = s.state;
            w[stat_sleep_pos]              = s.in_sleep;
            w[stat_doze_pos]               = s.ctrl.doze_enable;
            w[stat_cur_osc_lo +: 3]        = s.cur_osc;
         end
         default: w = 32'h0000_0000;
      endcase
      read_word = w;
   endfunction : read_word

   logic                  setup_phase;
   logic                  wr_access;
   logic                  wake_event;
   logic                  low_sleep;
   logic                  low_idle;
   logic                  doze_tick;
   logic                  in_run;
   logic [doze_count_w-1:0] doze_mask;

   // Setup decode needs no enable; frozen state ignores it
   assign setup_phase = psel && !penable;
   assign wr_access   = psel && penable && pwrite && clk_en;
   assign wake_event  = irq_pending || watchdog_timer_timeout;
   assign low_sleep   = (r_reg.state == ps_low) && r_reg.in_sleep;
   assign low_idle    = (r_reg.state == ps_low) && !r_reg.in_sleep;
   // Run decode shared by doze, switch and clock paths
   assign in_run      = (r_reg.state == ps_run);
   // divide by two to the n
   assign doze_mask   = doze_count_w'((8'h01 << r_reg.ctrl.doze_ratio) - 8'h01);
   assign doze_tick   = (r_reg.doze_cnt & doze_mask) == '0;

   always_comb begin
      r_next           = r_reg;
      r_next.resume    = 1'b0;
      r_next.wdt_clear = 1'b0;
      r_next.sw_start  = 1'b0;

      // Register read data latched in setup, so prdata is a flop
      if (setup_phase) begin
         r_next.rdata = read_word(r_reg, paddr);
         r_next.rerr  = !mapped(paddr);
      end

      if (wr_access) begin
         case (paddr)
            reset_control_off: begin
               r_next.ctrl.main_reg_active  = pwdata[main_reg_stby_pos];
               r_next.ctrl.flash_reg_active = pwdata[flash_reg_stby_pos];
            end
            clock_divisor_off: begin
               r_next.ctrl.doze_enable    = pwdata[doze_enable_pos];
               r_next.ctrl.doze_ratio     = pwdata[doze_ratio_hi:doze_ratio_lo];
               r_next.ctrl.recover_on_int = pwdata[recover_on_int_pos];
            end
            oscillator_control_off: begin
               if (!clock_config_locked) begin
                  r_next.ctrl.new_osc_sel = pwdata[new_osc_hi:new_osc_lo];
                  r_next.sw_start         = 1'b1;
               end
            end
            module_disable_off: begin
               // Bit lands now; module sees it a cycle later
               r_next.module_disable = pwdata[num_periph-1:0];
            end
            stop_in_idle_off: begin
               r_next.stop_in_idle = pwdata[num_periph-1:0];
            end
            default: begin
            end
         endcase
      end

      // one cycle from bit to module
      r_next.md_effective = r_reg.module_disable;

      // Switch completion ignored while halted
      if (osc_switch_done && in_run) begin
         r_next.cur_osc = r_reg.ctrl.new_osc_sel;
      end

      // doze counter paces CPU clock only
      // Counter runs on over ratio changes, no restart
      if (in_run && r_reg.ctrl.doze_enable) begin
         r_next.doze_cnt = r_reg.doze_cnt + 1'b1;
      end else begin
         r_next.doze_cnt = '0;
      end

      // interrupt ends doze if enabled
      // Hardware clear wins over a same-cycle write
      if (r_reg.ctrl.recover_on_int && irq_pending && in_run) begin
         r_next.ctrl.doze_enable = 1'b0;
      end

      case (r_reg.state)
         ps_run: begin
            if (power_save_instruction) begin
               r_next.state     = ps_enter;
               r_next.in_sleep  = power_save_sleep;
               r_next.saved_osc = r_reg.cur_osc;
               r_next.wdt_clear = watchdog_timer_en;
            end
         end
         // entry always completes first
         // Interrupts wait here; the core keeps them pending
         ps_enter: r_next.state = ps_low;
         ps_low: begin
            if (wake_event) begin
               r_next.state    = ps_wake;
               // Counting from one makes wake_cycles the stay
               r_next.wake_cnt = 3'h1;
               r_next.cur_osc  = r_reg.saved_osc;
            end
         end
         ps_wake: begin
            if (r_reg.wake_cnt >= 3'(wake_cycles)) begin
               r_next.state    = ps_run;
               r_next.in_sleep = 1'b0;
               r_next.resume   = 1'b1;
               r_next.wake_cnt = 3'h0;
            end else begin
               r_next.wake_cnt = r_reg.wake_cnt + 3'h1;
            end
         end
         default: r_next.state = ps_run;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg.state                 <= ps_run;
         r_reg.in_sleep              <= 1'b0;
         r_reg.ctrl.main_reg_active  <= 1'b0;
         r_reg.ctrl.flash_reg_active <= 1'b0;
         r_reg.ctrl.recover_on_int   <= 1'b0;
         r_reg.ctrl.doze_ratio       <= doze_ratio_rst;
         r_reg.ctrl.doze_enable      <= 1'b0;
         r_reg.ctrl.new_osc_sel      <= osc_sel_rst;
         r_reg.module_disable        <= '0;
         r_reg.md_effective          <= '0;
         r_reg.stop_in_idle          <= '0;
         r_reg.cur_osc               <= osc_sel_rst;
         r_reg.saved_osc             <= osc_sel_rst;
         r_reg.wake_cnt              <= 3'h0;
         r_reg.doze_cnt              <= '0;
         r_reg.resume                <= 1'b0;
         r_reg.wdt_clear             <= 1'b0;
         r_reg.sw_start              <= 1'b0;
         r_reg.rdata                 <= 32'h0000_0000;
         r_reg.rerr                  <= 1'b0;
      // Enable low freezes every bit, pulses included
      end else if (clk_en) begin
         r_reg <= r_next;
      end
   end

   // Zero wait states; held off while frozen
   assign pready  = psel && penable && clk_en;
   assign prdata  = r_reg.rdata;
   assign pslverr = r_reg.rerr;

   assign cpu_resume           = r_reg.resume;
   assign watchdog_timer_clear = r_reg.wdt_clear;
   assign osc_switch_start     = r_reg.sw_start;
   assign osc_switch_sel       = r_reg.ctrl.new_osc_sel;
   assign irq_hold             = (r_reg.state == ps_enter);

   always_comb begin
      // Sleep stops system clock and oscillator
      clk_out.sys_clk_run   = !low_sleep;
      clk_out.onchip_osc_on = !low_sleep;

      // CPU halted in Sleep and Idle
      clk_out.cpu_clk_en    = in_run &&
                              (!r_reg.ctrl.doze_enable || doze_tick);
      // RC clock in Sleep with watchdog
      // RC clock in Idle with watchdog or monitor
      if (low_sleep) begin
         clk_out.low_power_rc_run = watchdog_timer_en;
      end else begin
         clk_out.low_power_rc_run = watchdog_timer_en || fail_safe_clock_monitor_en;
      end

      clk_out.fail_safe_active  = fail_safe_clock_monitor_en && !low_sleep;
      // standby when bit clear
      // Regulators idle only in Sleep, never in Idle
      clk_out.main_reg_standby  = low_sleep && !r_reg.ctrl.main_reg_active;
      clk_out.flash_reg_standby = low_sleep && !r_reg.ctrl.flash_reg_active;
   end

   genvar gi;
   generate
      for (gi = 0; gi < num_periph; gi++) begin : g_periph
         // Delayed copy keeps clock and register enable together
         // present and not disabled
         assign periph_regs_en[gi] = present_mask[gi] && !r_reg.md_effective[gi];
         // only external-clock peripherals run in Sleep
         assign periph_clk_en[gi]  = periph_regs_en[gi] &&
                                     !(low_idle && r_reg.stop_in_idle[gi]) &&
                                     !(low_sleep && !ext_clk_mask[gi]);
      end
   endgenerate

endmodule : power_saving_clock_control
`default_nettype wire

// ### bench/power_clock_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module power_clock_monitor #(
   parameter int          num_periph   = 8,
   parameter logic [31:0] present_mask = 32'h0000_00ff,
   parameter logic [31:0] ext_clk_mask = 32'h0000_0000
) (
   // Clock and reset
   input wire logic                         pclk,
   input wire logic                         presetn,
   // Bus
   input wire logic                         psel,
   input wire logic                         penable,
   input wire logic                         pwrite,
   input wire logic                         pready,
   input wire logic [7:0]                   paddr,
   input wire logic [31:0]                  pwdata,
   // Core side
   input wire logic                         power_save_instruction,
   input wire logic                         power_save_sleep,
   input wire logic                         irq_pending,
   input wire logic                         watchdog_timer_en,
   input wire logic                         watchdog_timer_timeout,
   input wire logic                         fail_safe_clock_monitor_en,
   input wire logic                         clock_config_locked,
   input wire logic                         irq_hold,
   input wire logic                         cpu_resume,
   input wire logic                         watchdog_timer_clear,
   input wire logic                         osc_switch_start,
   input wire logic [2:0]                   osc_switch_sel,
   // Clock outputs
   input wire power_clock_pkg::clock_out_t  clk_out,
   input wire logic [num_periph-1:0]        periph_clk_en,
   input wire logic [num_periph-1:0]        periph_regs_en
);
   import power_clock_pkg::*;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic go;
   logic wr;
   // Run state only; a request in low power is ignored
   assign go = power_save_instruction && clk_out.cpu_clk_en && !irq_hold;
   assign wr = psel && penable && pwrite && pready;

   AST_SLEEP_ENTRY: assert property (go && power_save_sleep |=> irq_hold
      && !clk_out.cpu_clk_en ##1 !clk_out.sys_clk_run && !clk_out.onchip_osc_on
      && !clk_out.fail_safe_active) else $error("sleep entry outputs wrong");
   AST_IDLE_ENTRY: assert property (go && !power_save_sleep |=> irq_hold
      ##1 clk_out.sys_clk_run && !clk_out.cpu_clk_en) else $error("idle entry wrong");
   AST_WDT_CLEAR: assert property (go && watchdog_timer_en |=> watchdog_timer_clear)
      else $error("watchdog not cleared on entry");
   AST_RC_KEPT: assert property ($stable({watchdog_timer_en, fail_safe_clock_monitor_en})
      && (watchdog_timer_en || (fail_safe_clock_monitor_en && clk_out.sys_clk_run))
      |-> clk_out.low_power_rc_run) else $error("rc clock stopped");
   AST_SLEEP_PERIPH: assert property (!clk_out.sys_clk_run
      |-> (periph_clk_en & ~ext_clk_mask[num_periph-1:0]) == '0) else $error("periph clocked");
   AST_WAKE: assert property (irq_hold ##1 (irq_pending || watchdog_timer_timeout)
      |-> ##[3:5] cpu_resume) else $error("no resume after wake event");
   AST_RESUME_CLK: assert property (cpu_resume
      |-> clk_out.cpu_clk_en && !$past(clk_out.cpu_clk_en)) else $error("resume clock wrong");
   AST_PERIPH_DELAY: assert property (wr && paddr == module_disable_off
      && clk_out.cpu_clk_en |=> $stable(periph_clk_en) ##1 periph_regs_en == periph_clk_en
      && periph_clk_en == num_periph'(present_mask & ~$past(pwdata, 2)))
      else $error("module disable timing wrong");
   AST_OSC_START: assert property (wr && paddr == oscillator_control_off
      |=> osc_switch_start == !$past(clock_config_locked)) else $error("switch start wrong");
   AST_OSC_SEL: assert property (wr && paddr == oscillator_control_off && !clock_config_locked
      |=> osc_switch_sel == 3'($past(pwdata) >> 8)) else $error("switch select wrong");
endmodule : power_clock_monitor

bind power_saving_clock_control power_clock_monitor #(
   .num_periph(num_periph),
   .present_mask(present_mask),
   .ext_clk_mask(ext_clk_mask)
) u_power_clock_monitor (.*);
`default_nettype wire

// ### bench/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
   // Clock and reset
   input wire logic  pclk,
   input wire logic  presetn,
   // Bench commands
   input wire logic  cmd_go,
   input wire logic  cmd_sleep,
   input wire logic  cmd_irq,
   // Device side
   input wire logic  irq_hold,
   input wire logic  cpu_resume,
   output logic      power_save_instruction,
   output logic      power_save_sleep,
   output logic      irq_pending
);
   logic deferred_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_save_instruction <= 1'b0;
         power_save_sleep <= 1'b0;
         deferred_reg <= 1'b0;
      end else begin
         power_save_instruction <= cmd_go;
         // Operand is only meaningful with the pulse
         power_save_sleep <= cmd_go ? cmd_sleep : power_save_sleep;
         if (cmd_irq && irq_hold)
            deferred_reg <= 1'b1;
         else if (cpu_resume)
            deferred_reg <= 1'b0;
      end
   end
   assign irq_pending = cmd_irq || deferred_reg;
endmodule : cpu_core_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import power_clock_pkg::*;
   localparam logic [31:0] present = 32'h0000_007f;
   localparam logic [31:0] ext = 32'h0000_0003;
   logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr, periph_clk_en, periph_regs_en;
   logic [31:0] pwdata, prdata, rd;
   logic        power_save_instruction, power_save_sleep, irq_pending, irq_hold, cpu_resume;
   logic        watchdog_timer_en, watchdog_timer_timeout, fail_safe_clock_monitor_en;
   logic        clock_config_locked, osc_switch_done, watchdog_timer_clear, osc_switch_start;
   logic        cmd_go, cmd_sleep, cmd_irq;
   logic [2:0]  osc_switch_sel;
   clock_out_t  clk_out;
   int          num_errors, check_count, cycles, n;

   power_saving_clock_control #(.present_mask(present), .ext_clk_mask(ext))
      u_power_saving_clock_control (.*);
   cpu_core_model u_cpu_core_model (.*);

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task wrap_up;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   // Holds the request until pready is seen high at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task enter(input logic s, input logic i);
      @(posedge pclk);
      cmd_go <= 1'b1;
      cmd_sleep <= s;
      cmd_irq <= i;
      @(posedge pclk);
      cmd_go <= 1'b0;
      n = 0;
      while (irq_hold !== 1'b1 && n < 20) begin
         @(posedge pclk);
         #1;
         n++;
      end
      chk(watchdog_timer_clear, watchdog_timer_en);
      @(posedge pclk);
      cmd_irq <= 1'b0;
      #1;
   endtask : enter

   task wake_count;
      n = 0;
      while (cpu_resume !== 1'b1 && n < 20) begin
         @(posedge pclk);
         #1;
         n++;
      end
   endtask : wake_count

   task t_reset;
      apb(0, reset_control_off, 0);
      chk(rd, 0);
      apb(0, clock_divisor_off, 0);
      chk(rd, 0);
      apb(0, module_disable_off, 0);
      chk(rd, 0);
      chk(32'(periph_clk_en), present);
      apb(0, 8'h18, 0);
      chk(32'(er), 1);
   endtask : t_reset

   task t_pmd;
      apb(1, module_disable_off, 32'h05);
      @(posedge pclk);
      #1;
      chk(32'(periph_clk_en), 32'h7a);
      chk(32'(periph_regs_en), 32'h7a);
      apb(1, module_disable_off, 32'h80);
      @(posedge pclk);
      #1;
      chk(32'(periph_clk_en), present);
   endtask : t_pmd

   task t_doze;
      for (int r = 0; r < 8; r++) begin
         apb(1, clock_divisor_off, 32'h800 | (r << 12));
         n = 0;
         repeat (128) begin
            @(posedge pclk);
            #1;
            if (clk_out.cpu_clk_en === 1'b1)
               n++;
         end
         chk(n, 128 >> r);
         chk(32'(clk_out.sys_clk_run), 1);
      end
      @(posedge pclk);
      cmd_irq <= 1'b1;
      repeat (3) @(posedge pclk);
      cmd_irq <= 1'b0;
      apb(0, clock_divisor_off, 0);
      chk(rd, 32'h7800);
      apb(1, clock_divisor_off, 32'hb800);
      cmd_irq <= 1'b1;
      repeat (3) @(posedge pclk);
      cmd_irq <= 1'b0;
      apb(0, clock_divisor_off, 0);
      chk(rd, 32'hb000);
      apb(1, clock_divisor_off, 0);
   endtask : t_doze

   task t_sleep;
      apb(1, oscillator_control_off, 32'h500);
      osc_switch_done <= 1'b1;
      @(posedge pclk);
      osc_switch_done <= 1'b0;
      clock_config_locked <= 1'b1;
      apb(1, oscillator_control_off, 32'h200);
      apb(0, oscillator_control_off, 0);
      chk(rd, 32'h505);
      apb(1, reset_control_off, 32'h100);
      enter(1'b1, 1'b1);
      chk(32'(clk_out), 32'h09);
      chk(32'(periph_clk_en), present & ext);
      wake_count;
      chk(32'(n >= 3 && n <= 5), 1);
      apb(0, oscillator_control_off, 0);
      chk(rd, 32'h505);
   endtask : t_sleep

   task t_idle;
      apb(1, stop_in_idle_off, 1);
      enter(1'b0, 1'b0);
      chk(32'(clk_out), 32'h3c);
      chk(32'(periph_clk_en), 32'h7e);
      repeat (4) @(posedge pclk);
      watchdog_timer_timeout <= 1'b1;
      wake_count;
      @(posedge pclk);
      watchdog_timer_timeout <= 1'b0;
      chk(32'(n >= 3 && n <= 5), 1);
   endtask : t_idle

   // Cuts a hang short
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         wrap_up;
      end
   end

   initial begin
      cycles = 0;
      num_errors = 0;
      check_count = 0;
      presetn = 1'b0;
      clk_en = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cmd_go = 1'b0;
      cmd_sleep = 1'b0;
      cmd_irq = 1'b0;
      watchdog_timer_en = 1'b1;
      watchdog_timer_timeout = 1'b0;
      fail_safe_clock_monitor_en = 1'b1;
      clock_config_locked = 1'b0;
      osc_switch_done = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_pmd;
      t_doze;
      t_sleep;
      t_idle;
      wrap_up;
   end
endmodule : tb_top
`default_nettype wire
